/* File: core/adc_mode_command_sequencer.sv */
// Purpose: serial command interpreter and mode control of the converter
// Assumes: clk at 250 MHz, link pins sampled through two flip-flops
// Notes: conversion data come from the analog side on conv_data
`timescale 1ns/100ps
module adc_mode_command_sequencer
	import sequencer_pkg::*;
#(
	parameter int LIGHT_WAKE = LIGHT_WAKE_CYC,
	parameter int DEEP_WAKE  = DEEP_WAKE_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial link pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	// hardware power-down pin
	input  wire logic        pd_n,
	// analog side
	input  wire logic [11:0] conv_data,
	input  wire logic [8:0]  alarm_in,
	output logic             sample_strobe,
	output logic [3:0]       sample_channel,
	output logic             alarm_out,
	// status
	output logic [2:0]       mode_state,
	output logic             bias_ready,
	output logic             reference_on
);
	logic [3:0] pins_s;
	logic       cs_s;
	logic       sclk_s;
	logic       sdi_s;
	logic       pd_s;
	logic       cs_prev_reg;
	logic       sclk_prev_reg;

	pin_sync #(.WIDTH(4), .INIT(4'b1011)) u_sync (
		.clk          (clk),
		.rst_n        (rst_n),
		.pin_in       ({pd_n, sdi, sclk, cs_n}),
		.pin_sync_out (pins_s)
	);
	assign cs_s   = pins_s[0];
	assign sclk_s = pins_s[1];
	assign sdi_s  = pins_s[2];
	assign pd_s   = pins_s[3];

	// edges of the sampled link pins
	wire frame_start = cs_prev_reg && !cs_s;
	wire frame_end   = !cs_prev_reg && cs_s;
	wire sclk_fall   = sclk_prev_reg && !sclk_s && !cs_s;

	mode_t       mode_reg, mode_next;
	logic [5:0]  bit_cnt_reg;
	logic [14:0] cmd_shift_reg;
	logic [15:0] cmd_reg;
	logic        cmd_done_reg;
	logic [15:0] out_shift_reg;
	logic        sdo_reg;
	logic [7:0]  scan_first_reg;
	logic [7:0]  scan_second_reg;
	logic [3:0]  chan_reg, chan_next;
	logic [3:0]  alarm_ch_reg;
	logic [22:0] wake_cnt_reg;
	logic        sample_reg;
	logic [3:0]  sample_ch_reg;
	logic        alarm_reg;
	logic        pd_seen_reg;

	scan_if sc ();
	channel_picker u_pick (.sc(sc));
	assign sc.enabled = scan_first_reg & ~scan_second_reg;
	assign sc.current = chan_reg;

	// command decode; the word is whole only after the 16th falling edge
	wire [15:0] word_in   = {cmd_shift_reg, sdi_s};
	wire        last_bit  = sclk_fall && (bit_cnt_reg == 6'(CMD_BITS - 1));
	wire        is_hold   = (cmd_reg == CMD_HOLD);
	wire        is_light  = (cmd_reg == CMD_LIGHT);
	wire        is_deep   = (cmd_reg == CMD_DEEP);
	wire        is_rreset = (cmd_reg == CMD_REG_RESET);
	wire        is_auto   = (cmd_reg == CMD_AUTO);
	wire        is_aux    = (cmd_reg == CMD_AUX);
	wire        is_fixed  = (cmd_reg[15:13] == CMD_FIXED_TOP)
	                        && (cmd_reg[FIXED_CH_LSB-1:0] == 10'h000);
	wire        is_reg    = !cmd_reg[15] && !is_hold;
	wire        reg_wr    = is_reg && cmd_reg[REG_WR_BIT];
	wire [6:0]  reg_addr  = cmd_reg[15:REG_ADDR_LSB];
	wire        in_reg    = !word_in[15] && (word_in != CMD_HOLD);
	wire [6:0]  in_addr   = word_in[15:REG_ADDR_LSB];
	wire        sleeping  = (mode_reg == LIGHT_SLEEP_MODE) || (mode_reg == DEEP_SLEEP_MODE);
	wire        converting= (mode_reg == AUTO_SCAN_MODE) || (mode_reg == FIXED_CHANNEL_MODE);
	wire        execute   = frame_end && cmd_done_reg;
	wire        abort     = frame_end && !cmd_done_reg;
	wire        is_read   = is_reg && !reg_wr;
	// a read leaves either sleep in place, so the wake wait on exit is not skipped
	wire        read_mode = is_read && !sleeping;
	wire        hw_exit   = pd_s && pd_seen_reg;
	wire        in_read   = in_reg && !word_in[REG_WR_BIT];
	wire        result_ok = converting && (wake_cnt_reg == 23'h00_0000);
	wire        take_smp  = frame_start && converting;

	// register writes and the two ways back to defaults
	wire        regs_dflt = !pd_s || (execute && is_rreset);
	wire        wr_first  = execute && reg_wr && (reg_addr == SCAN_FIRST_OFS);
	wire        wr_second = execute && reg_wr && (reg_addr == SCAN_SECOND_OFS);

	wire [7:0] read_data = (in_addr == SCAN_FIRST_OFS)  ? scan_first_reg :
	                       (in_addr == SCAN_SECOND_OFS) ? scan_second_reg : 8'h00;

	// word shifted out after the command: register read, result or junk
	wire [15:0] out_word = in_read ? {read_data, 8'h00} :
	                       result_ok ? {conv_data, 4'h0} :
	                       JUNK_WORD;

	always_comb begin
		mode_next = mode_reg;
		chan_next = chan_reg;
		if (!pd_s) begin
			mode_next = DEEP_SLEEP_MODE;
		end else if (hw_exit) begin
			mode_next = IDLE_MODE;
		end else if (abort) begin
			mode_next = INVALID_MODE;
		end else if (execute) begin
			if (is_hold) begin
				if (mode_reg == REGISTER_ACCESS_MODE) begin
					mode_next = IDLE_MODE;
				end
			end else if (is_light) begin
				mode_next = LIGHT_SLEEP_MODE;
			end else if (is_deep) begin
				mode_next = DEEP_SLEEP_MODE;
			end else if (is_rreset) begin
				mode_next = IDLE_MODE;
			end else if (is_auto) begin
				mode_next = AUTO_SCAN_MODE;
				chan_next = sc.first;
			end else if (is_fixed) begin
				mode_next = FIXED_CHANNEL_MODE;
				chan_next = {1'b0, cmd_reg[12:FIXED_CH_LSB]};
			end else if (is_aux) begin
				mode_next = FIXED_CHANNEL_MODE;
				chan_next = AUX_CHANNEL;
			end else if (read_mode) begin
				mode_next = REGISTER_ACCESS_MODE;
			end
			// unknown words fall through unchanged
		end else if (frame_start && mode_reg == AUTO_SCAN_MODE) begin
			chan_next = sc.next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_prev_reg <= 1'b1;
		end else begin
			cs_prev_reg <= cs_s;
		end
	end

	// resets low while the idle link clock is high, so no false fall follows reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end

	// mode holds across frames of zero words, except register access mode, which returns to idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_reg <= IDLE_MODE;
			chan_reg <= 4'h0;
		end else begin
			mode_reg <= mode_next;
			chan_reg <= chan_next;
		end
	end

	// serial shifter; counting stops at the full frame length
	always_ff @(posedge clk) begin
		if (!rst_n || frame_start) begin
			bit_cnt_reg   <= 6'h00;
			cmd_shift_reg <= 15'h0000;
		end else if (sclk_fall && bit_cnt_reg != 6'(FULL_FRAME)) begin
			bit_cnt_reg   <= bit_cnt_reg + 6'h01;
			cmd_shift_reg <= word_in[14:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || frame_start) begin
			cmd_done_reg <= 1'b0;
		end else if (last_bit) begin
			cmd_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || frame_start) begin
			cmd_reg <= CMD_HOLD;
		end else if (last_bit) begin
			cmd_reg <= word_in;
		end
	end

	// output word leaves msb first from the 16th falling edge on
	always_ff @(posedge clk) begin
		if (!rst_n || frame_start) begin
			out_shift_reg <= 16'h0000;
			sdo_reg       <= 1'b0;
		end else if (last_bit) begin
			out_shift_reg <= {out_word[14:0], 1'b0};
			sdo_reg       <= out_word[15];
		end else if (sclk_fall && cmd_done_reg) begin
			out_shift_reg <= {out_shift_reg[14:0], 1'b0};
			sdo_reg       <= out_shift_reg[15];
		end
	end
	assign sdo    = sdo_reg;
	assign sdo_oe = !cs_s;

	// program registers; writes go through in every mode
	always_ff @(posedge clk) begin
		if (!rst_n || regs_dflt) begin
			scan_first_reg <= SCAN_FIRST_RST;
		end else if (wr_first) begin
			scan_first_reg <= cmd_reg[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || regs_dflt) begin
			scan_second_reg <= SCAN_SECOND_RST;
		end else if (wr_second) begin
			scan_second_reg <= cmd_reg[7:0];
		end
	end
	// light and deep sleep exits by a scan command never touch these registers

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pd_seen_reg <= 1'b0;
		end else begin
			pd_seen_reg <= !pd_s;
		end
	end

	// wake timers start when a scan command ends a sleep
	wire leave_sleep = sleeping && (mode_next == AUTO_SCAN_MODE
	                   || mode_next == FIXED_CHANNEL_MODE);
	wire wake_light  = leave_sleep && (mode_reg == LIGHT_SLEEP_MODE);
	wire wake_deep   = leave_sleep && (mode_reg == DEEP_SLEEP_MODE);
	// one counter serves both exits, so its width follows the deep wait
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_cnt_reg <= 23'h00_0000;
		end else if (wake_light) begin
			wake_cnt_reg <= 23'(LIGHT_WAKE);
		end else if (wake_deep) begin
			wake_cnt_reg <= 23'(DEEP_WAKE);
		end else if (wake_cnt_reg != 23'h00_0000) begin
			wake_cnt_reg <= wake_cnt_reg - 23'h00_0001;
		end
	end
	assign bias_ready   = (wake_cnt_reg == 23'h00_0000) && !sleeping;
	assign reference_on = (mode_reg != DEEP_SLEEP_MODE);

	// sampling at the frame start; invalid and sleep modes take no sample
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_reg <= 1'b0;
		end else begin
			sample_reg <= take_smp;
		end
	end

	// an abort leaves the alarm on the channel sampled last
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_ch_reg <= 4'h0;
			alarm_ch_reg  <= 4'h0;
		end else if (take_smp) begin
			sample_ch_reg <= chan_reg;
			alarm_ch_reg  <= chan_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alarm_reg <= 1'b0;
		end else begin
			alarm_reg <= alarm_in[alarm_ch_reg];
		end
	end

	assign sample_strobe  = sample_reg;
	assign sample_channel = sample_ch_reg;
	assign alarm_out      = alarm_reg;
	assign mode_state     = mode_reg;
endmodule : adc_mode_command_sequencer

/* File: core/channel_picker.sv */
// Purpose: finds the lowest enabled channel and the next one above a position
// Assumes: eight channels
// Notes: an empty mask yields channel 0
`timescale 1ns/100ps
module channel_picker (
	// scan position and answer
	scan_if.picker sc
);
	logic [3:0] low_ch;
	logic [3:0] above_ch;
	logic       above_found;

	always_comb begin
		low_ch      = 4'h0;
		above_ch    = 4'h0;
		above_found = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (sc.enabled[i]) begin
				low_ch = 4'(i);
			end
			if (sc.enabled[i] && (4'(i) > sc.current)) begin
				above_ch    = 4'(i);
				above_found = 1'b1;
			end
		end
	end

	assign sc.first = low_ch;
	assign sc.next  = above_found ? above_ch : low_ch;
endmodule : channel_picker

/* File: core/pin_sync.sv */
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: synchronous active-low reset
// Notes: only the second stage leaves this module
`timescale 1ns/100ps
module pin_sync #(
	parameter int           WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and synchronised copy
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_reg   <= INIT;
			pin_sync_out <= INIT;
		end else begin
			stage1_reg   <= pin_in;
			pin_sync_out <= stage1_reg;
		end
	end
endmodule : pin_sync

/* File: core/scan_if.sv */
// Purpose: carries the channel mask and scan position to the channel picker
// Assumes: eight scannable channels
// Notes: picker answers combinationally
`timescale 1ns/100ps
interface scan_if;
	logic [7:0] enabled;
	logic [3:0] current;
	logic [3:0] first;
	logic [3:0] next;

	modport seq    (output enabled, output current, input first, input next);
	modport picker (input enabled, input current, output first, output next);
endinterface : scan_if

/* File: core/sequencer_pkg.sv */
// Purpose: shared constants and types of the command sequencer
// Assumes: 250 MHz system clock, 16-bit command words, 8 analog channels plus aux
// Notes: program register access words have bit 15 clear
package sequencer_pkg;

	localparam int          CMD_BITS       = 16;
	localparam int          FULL_FRAME     = 32;
	localparam logic [15:0] CMD_HOLD       = 16'h0000;
	localparam logic [15:0] CMD_LIGHT      = 16'h8200;
	localparam logic [15:0] CMD_DEEP       = 16'h8300;
	localparam logic [15:0] CMD_REG_RESET  = 16'h8500;
	localparam logic [15:0] CMD_AUTO       = 16'hA000;
	localparam logic [15:0] CMD_AUX        = 16'hE000;
	localparam logic [2:0]  CMD_FIXED_TOP  = 3'h6;
	localparam int          FIXED_CH_LSB   = 10;
	localparam logic [3:0]  AUX_CHANNEL    = 4'h8;

	// register access word: address 15:9 (bit 15 zero), write flag 8, data 7:0
	localparam int          REG_ADDR_LSB   = 9;
	localparam int          REG_WR_BIT     = 8;
	localparam logic [6:0]  SCAN_FIRST_OFS = 7'h01;
	localparam logic [6:0]  SCAN_SECOND_OFS= 7'h02;
	localparam logic [7:0]  SCAN_FIRST_RST = 8'hFF;
	localparam logic [7:0]  SCAN_SECOND_RST= 8'h00;

	localparam logic [15:0] JUNK_WORD      = 16'hFFFF;

	localparam int          CLK_MHZ        = 250;
	localparam int          LIGHT_WAKE_US  = 20;
	localparam int          DEEP_WAKE_MS   = 15;
	localparam int          LIGHT_WAKE_CYC = LIGHT_WAKE_US * CLK_MHZ;
	localparam int          DEEP_WAKE_CYC  = DEEP_WAKE_MS * 1000 * CLK_MHZ;

	typedef enum logic [2:0] {
		IDLE_MODE            = 3'b000,
		LIGHT_SLEEP_MODE     = 3'b001,
		DEEP_SLEEP_MODE      = 3'b010,
		AUTO_SCAN_MODE       = 3'b011,
		FIXED_CHANNEL_MODE   = 3'b100,
		INVALID_MODE         = 3'b101,
		REGISTER_ACCESS_MODE = 3'b110
	} mode_t;

endpackage : sequencer_pkg

/* File: testbench/adc_mode_command_sequencer_tb.sv */
// Purpose: self-checking bench of the command sequencer
// Assumes: short wake counts, host model drives the link
// Notes: driver queues expected words and channels, a monitor pops them
`timescale 1ns/100ps
module adc_mode_command_sequencer_tb;
	import sequencer_pkg::*;
	localparam int         NO = -1;
	localparam int         CV = -2;
	localparam logic [2:0] ANY = 3'h7;
	typedef struct packed {logic [2:0] mode; logic chk; logic [15:0] word;} note_t;
	logic        clk, rst_n, pd_n, cs_n, sclk, sdi, sdo, sdo_oe, strobe;
	logic        alarm_out, bias_ready, reference_on, rx_valid;
	logic [11:0] conv_data;
	logic [8:0]  alarm_in;
	logic [3:0]  channel;
	logic [2:0]  mode_state;
	logic [15:0] rx_word;
	logic [31:0] seed;
	note_t       note_q[$];
	note_t       nt;
	logic [3:0]  ch_q[$];
	int          n_mismatch;
	int          n_tests;
	int          prev;
	adc_mode_command_sequencer #(.LIGHT_WAKE(20), .DEEP_WAKE(50)) DUT (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe), .pd_n(pd_n), .conv_data(conv_data), .alarm_in(alarm_in),
		.sample_strobe(strobe), .sample_channel(channel), .alarm_out(alarm_out),
		.mode_state(mode_state), .bias_ready(bias_ready), .reference_on(reference_on));
	host_link host (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.rx_valid(rx_valid), .rx_word(rx_word));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// e: word to expect, NO for none, CV for the converted sample
	task automatic xfer(input logic [15:0] w, input int n, input logic [2:0] m, input int e,
		input int sc);
		if (sc >= 0)
			ch_q.push_back(sc[3:0]);
		conv_data <= seed[11:0];
		alarm_in <= seed[20:12];
		note_q.push_back('{m, e != NO, (e == CV) ? {seed[11:0], 4'h0} : e[15:0]});
		seed = xorshift(seed);
		host.frame(w, n);
	endtask : xfer
	always @(posedge clk) begin
		if (rx_valid && note_q.size() > 0) begin
			nt = note_q.pop_front();
			if (nt.mode !== ANY)
				check("mode", 16'(nt.mode), 16'(mode_state));
			if (nt.mode === DEEP_SLEEP_MODE)
				check("reference", 16'h0000, 16'(reference_on));
			if (nt.chk)
				check("word", nt.word, rx_word);
		end
		if (strobe === 1'b1) begin
			if (ch_q.size() == 0)
				check("stray sample", 16'h0000, 16'h0001);
			else
				check("channel", 16'(ch_q.pop_front()), 16'(channel));
		end
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		seed = 32'h5f70_56fb;
		rst_n = 1'b0;
		pd_n = 1'b1;
		conv_data = 12'h000;
		alarm_in = 9'h000;
		n_mismatch = 0;
		n_tests = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		xfer(16'h0000, 16, IDLE_MODE, NO, NO);
		xfer(16'h05F8, 16, ANY, NO, NO);
		xfer(16'h0200, 32, REGISTER_ACCESS_MODE, 16'hFF00, NO);
		xfer(16'h0400, 32, REGISTER_ACCESS_MODE, 16'hF800, NO);
		xfer(16'h0000, 16, IDLE_MODE, NO, NO);
		$display("test registers done");
		xfer(16'hA000, 32, AUTO_SCAN_MODE, NO, NO);
		for (int i = 0; i < 4; i++)
			xfer(16'h0000, 32, AUTO_SCAN_MODE, CV, i % 3);
		xfer(16'hA000, 16, AUTO_SCAN_MODE, NO, 1);
		xfer(16'h0000, 16, AUTO_SCAN_MODE, NO, 0);
		$display("test scan done");
		prev = 1;
		for (int i = 0; i < 8; i++) begin
			xfer(16'hC000 + 16'(i) * 16'h0400, 16, FIXED_CHANNEL_MODE, NO, prev);
			prev = i;
		end
		xfer(16'hE000, 16, FIXED_CHANNEL_MODE, NO, 7);
		xfer(16'h9000, 16, FIXED_CHANNEL_MODE, NO, 8);
		xfer(16'h0000, 32, FIXED_CHANNEL_MODE, CV, 8);
		xfer(16'hC400, 8, INVALID_MODE, NO, 8);
		xfer(16'h0000, 32, ANY, JUNK_WORD, NO);
		$display("test fixed and abort done");
		xfer(16'h8200, 16, LIGHT_SLEEP_MODE, NO, NO);
		xfer(16'h0000, 32, LIGHT_SLEEP_MODE, JUNK_WORD, NO);
		xfer(16'h05F0, 16, ANY, NO, NO);
		xfer(16'hA000, 16, AUTO_SCAN_MODE, NO, NO);
		xfer(16'h0000, 16, AUTO_SCAN_MODE, NO, 0);
		xfer(16'h0000, 32, AUTO_SCAN_MODE, CV, 1);
		$display("test light sleep done");
		xfer(16'h8300, 16, DEEP_SLEEP_MODE, NO, 2);
		xfer(16'h0000, 32, DEEP_SLEEP_MODE, JUNK_WORD, NO);
		xfer(16'h0400, 32, DEEP_SLEEP_MODE, 16'hF000, NO);
		xfer(16'hC800, 16, FIXED_CHANNEL_MODE, NO, NO);
		xfer(16'h0000, 32, FIXED_CHANNEL_MODE, CV, 2);
		$display("test deep sleep done");
		pd_n <= 1'b0;
		repeat (8) @(posedge clk);
		pd_n <= 1'b1;
		repeat (8) @(posedge clk);
		xfer(16'h0400, 32, REGISTER_ACCESS_MODE, 16'h0000, NO);
		$display("test power pin done");
		check("queues", 16'h0000, 16'(note_q.size() + ch_q.size()));
		give_verdict();
	end
endmodule : adc_mode_command_sequencer_tb

/* File: testbench/host_link.sv */
// Purpose: host side of the serial link, one frame per call
// Assumes: link clock period of 2*HALF system clocks
// Notes: link clock idles high; data line toggles once unused
`timescale 1ns/100ps
module host_link #(
	parameter int HALF = 10,
	parameter int GAP  = 60
) (
	// clock and link
	input wire logic    clk,
	input wire logic    sdo,
	output logic        cs_n,
	output logic        sclk,
	output logic        sdi,
	// captured reply
	output logic        rx_valid,
	output logic [15:0] rx_word
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
		rx_valid = 1'b0;
		rx_word = 16'h0000;
	end
	task automatic frame(input logic [15:0] w, input int n);
		@(posedge clk) cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi <= (i < 16) ? w[15 - i] : ~sdi;
			repeat (HALF) @(posedge clk);
			if (i >= 16)
				rx_word <= {rx_word[14:0], sdo};
			sclk <= 1'b0;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		repeat (6) @(posedge clk);
		rx_valid <= 1'b1;
		@(posedge clk) rx_valid <= 1'b0;
		// gap covers both wake waits, so exits never sample early
		repeat (GAP) @(posedge clk);
	endtask : frame
endmodule : host_link

/* File: testbench/seq_chk.sv */
// Purpose: port-level checks of the command sequencer
// Assumes: one clock domain, wake counts handed down by bind
// Notes: wake_cnt counts scanning cycles spent waiting for bias
`timescale 1ns/100ps
module seq_chk
	import sequencer_pkg::*;
#(
	parameter int LIGHT_WAKE = LIGHT_WAKE_CYC,
	parameter int DEEP_WAKE  = DEEP_WAKE_CYC
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// pins
	input wire logic       cs_n,
	input wire logic       pd_n,
	input wire logic [8:0] alarm_in,
	// watched outputs
	input wire logic       sdo_oe,
	input wire logic       sample_strobe,
	input wire logic [3:0] sample_channel,
	input wire logic       alarm_out,
	input wire logic [2:0] mode_state,
	input wire logic       bias_ready,
	input wire logic       reference_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	int  wake_cnt;
	wire scanning;
	wire sleeping;
	assign scanning = mode_state == AUTO_SCAN_MODE || mode_state == FIXED_CHANNEL_MODE;
	assign sleeping = mode_state == LIGHT_SLEEP_MODE || mode_state == DEEP_SLEEP_MODE;
	// cleared whenever bias is up, so a stuck timer shows as a runaway count
	always_ff @(posedge clk) begin
		if (!rst_n || bias_ready || !scanning)
			wake_cnt <= 0;
		else
			wake_cnt <= wake_cnt + 1;
	end
	a_oe_in_frame: assert property ($fell(cs_n) |-> ##[1:4] sdo_oe)
		else $error("output not enabled in frame");
	a_oe_off_idle: assert property (cs_n [*4] |-> !sdo_oe)
		else $error("output enabled outside frame");
	a_mode_in_frame: assert property ((!cs_n && pd_n) [*6] |-> $stable(mode_state))
		else $error("mode changed inside frame");
	a_strobe_active: assert property (sample_strobe |-> scanning && !cs_n)
		else $error("sample taken while not converting");
	a_strobe_once: assert property (sample_strobe |=> !sample_strobe [*8])
		else $error("more than one sample in frame");
	a_alarm_follow: assert property ($past(rst_n) && $stable(sample_channel)
		&& $stable(alarm_in) |-> alarm_out == alarm_in[sample_channel])
		else $error("alarm not from sampled channel");
	a_deep_ref_off: assert property ((mode_state == DEEP_SLEEP_MODE) [*2] |-> !reference_on)
		else $error("reference on in deep sleep");
	a_ref_on_awake: assert property ((mode_state != DEEP_SLEEP_MODE) [*2] |-> reference_on)
		else $error("reference off outside deep sleep");
	a_sleep_no_bias: assert property (sleeping [*2] |-> !bias_ready)
		else $error("bias ready while sleeping");
	a_wake_bound: assert property (wake_cnt <= DEEP_WAKE + 2)
		else $error("wake wait too long");
	a_wake_min: assert property ($rose(bias_ready) && $past(scanning)
		|-> $past(wake_cnt) + 2 >= LIGHT_WAKE)
		else $error("bias ready too early");
	a_pin_deep: assert property (!pd_n [*4] |-> mode_state == DEEP_SLEEP_MODE)
		else $error("power pin ignored");
	c_auto: cover property (sample_strobe && mode_state == AUTO_SCAN_MODE);
	c_light: cover property (mode_state == LIGHT_SLEEP_MODE);
	c_invalid: cover property (mode_state == INVALID_MODE);
	c_wake: cover property ($rose(bias_ready));
endmodule : seq_chk

bind adc_mode_command_sequencer seq_chk #(.LIGHT_WAKE(LIGHT_WAKE), .DEEP_WAKE(DEEP_WAKE)) chk (
	.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .pd_n(pd_n), .alarm_in(alarm_in),
	.sdo_oe(sdo_oe), .sample_strobe(sample_strobe), .sample_channel(sample_channel),
	.alarm_out(alarm_out), .mode_state(mode_state), .bias_ready(bias_ready),
	.reference_on(reference_on));
